/* File: simd_compare_dot_accumulate.sv */
// apb-attached execution datapath for byte-vector compares, halfword
// dot products and a saturating word multiply-accumulate.
// assumes a single pclk domain and an apb master that holds each
// request until pready; every access completes with no wait state.
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - compare four unsigned byte lanes, eq/lt/le
// - lane results to status bits 27..24
// - no value-dependent exceptions; flags only
// - signed upper and lower halfword products
// - integer sum extended, accumulator wraps
// - integer dot leaves saturation flags alone
// - two-bit selector picks accumulator pair 0..3
// - q15 products shifted left one bit
// - minus one squared gives q31 maximum
// - q31 products extended, summed, accumulate unsaturated
// - halfword saturation sets flag 16 plus selector
// - q31 word product saturates, then accumulates
// - accumulator overflow clamps to q63 limits
// - any word saturation sets selector's flag
// - most-negative squared gives maximum, sets flag
module simd_compare_dot_accumulate
	import simd_dot_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// events
	output logic             irq,
	output logic             unusable_exception
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [31:0] ctrl_q;
	logic [31:0] status_q;
	logic [31:0] status_d;
	logic [2:0]  irq_stat_q;
	logic [2:0]  irq_stat_d;
	logic [2:0]  irq_mask_q;
	operands_t   ops_q;
	cmd_t        cmd_q;
	logic [63:0] acc_q [4];
	logic [63:0] acc_d;
	logic        acc_we;
	logic        unusable_q;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	function automatic logic is_acc(input logic [7:0] a);
		return (a >= ADDR_ACC_BASE) && (a <= ADDR_ACC_LAST);
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		return is_acc(a) || (a <= ADDR_IRQ_MASK);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
	                                      input logic [31:0] nw,
	                                      input logic [3:0]  st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	logic       wr;
	logic       rd;
	logic [1:0] acc_idx;
	logic       acc_top;
	cmd_t       new_cmd;
	logic       issue;

	assign wr      = psel && penable && pwrite && is_mapped(paddr);
	assign rd      = psel && penable && !pwrite;
	assign acc_idx = paddr[4:3];
	assign acc_top = !paddr[2];
	assign new_cmd = cmd_t'(pwdata[5:0]);
	assign issue   = wr && (paddr == ADDR_CMD) && pstrb[0];
	// zero wait states; unaligned or unmapped addresses answer error
	assign pready  = 1'b1;
	assign pslverr = psel && penable &&
	                 (!is_mapped(paddr) || (paddr[1:0] != 2'b00));

	// ----------------------------------------------------------------
	// datapath units
	// ----------------------------------------------------------------
	operands_t   cur_ops;
	logic [3:0]  cmp_flags;
	cmp_mode_t   cmp_mode;
	logic [31:0] q15_prod [2];
	logic [1:0]  q15_sat;

	assign cur_ops = ops_q;

	always_comb begin
		case (new_cmd.op)
			OP_BYTE_LANES_LESS_COMPARE:       cmp_mode = CMP_LT;
			OP_BYTE_LANES_LESS_EQUAL_COMPARE: cmp_mode = CMP_LE;
			default:                          cmp_mode = CMP_EQ;
		endcase
	end

	byte_lane_compare u_cmp (
		.ops   (cur_ops),
		.mode  (cmp_mode),
		.flags (cmp_flags)
	);

	// lane 1 pairs the upper halfwords, lane 0 the lower ones
	genvar h;
	generate
		for (h = 0; h < 2; h++) begin : g_q15
			q15_multiply u_mul (
				.a         (ops_q.left_operand[16*h +: 16]),
				.b         (ops_q.right_operand[16*h +: 16]),
				.product   (q15_prod[h]),
				.saturated (q15_sat[h])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// execute: one command completes in the cycle it is written
	// ----------------------------------------------------------------
	logic signed [31:0] upper_prod;
	logic signed [31:0] lower_prod;
	logic signed [32:0] int_dot;
	logic signed [63:0] frac_dot;
	logic signed [63:0] word_prod;
	logic               word_psat;
	logic signed [64:0] word_sum;
	logic [63:0]        sel_acc;
	logic               sat_evt;
	logic               enabled;

	assign enabled = ctrl_q[CTRL_EN_BIT];
	assign sel_acc = acc_q[new_cmd.sum_pair_select];

	always_comb begin
		upper_prod  = 32'($signed(ops_q.left_operand[31:16])) *
			32'($signed(ops_q.right_operand[31:16]));
		lower_prod  = 32'($signed(ops_q.left_operand[15:0])) *
			32'($signed(ops_q.right_operand[15:0]));
		int_dot     = 33'(upper_prod) + 33'(lower_prod);
		frac_dot    = 64'($signed(q15_prod[1])) +
		              64'($signed(q15_prod[0]));
		word_psat   = (ops_q.left_operand == Q31_MIN) &&
		              (ops_q.right_operand == Q31_MIN);
		word_prod   = (64'($signed(ops_q.left_operand)) *
			64'($signed(ops_q.right_operand))) <<< 1;
		if (word_psat) begin
			word_prod = $signed(Q63_MAX);
		end
		word_sum = {sel_acc[63], sel_acc} + {word_prod[63], word_prod};
	end

	// result selection; a disabled unit writes no status bits and no accumulator
	always_comb begin
		status_d = status_q;
		acc_d    = sel_acc;
		acc_we   = 1'b0;
		sat_evt  = 1'b0;
		if (issue && enabled) begin
			case (new_cmd.op)
				OP_BYTE_LANES_EQUAL_COMPARE,
				OP_BYTE_LANES_LESS_COMPARE,
				OP_BYTE_LANES_LESS_EQUAL_COMPARE: begin
					status_d[CC_LSB +: 4] = cmp_flags;
				end
				OP_INTEGER_PAIR_DOT_ACCUMULATE: begin
					// saturation field untouched, sum wraps
					acc_d  = sel_acc + 64'(int_dot);
					acc_we = 1'b1;
				end
				OP_FRACTIONAL_PAIR_DOT_ACCUMULATE: begin
					acc_d   = sel_acc + 64'(frac_dot);
					acc_we  = 1'b1;
					sat_evt = |q15_sat;
				end
				OP_FRACTIONAL_WORD_SATURATING_MAC: begin
					acc_we  = 1'b1;
					sat_evt = word_psat;
					if (word_sum[64] != word_sum[63]) begin
						sat_evt = 1'b1;
						acc_d   = word_sum[64] ? Q63_MIN : Q63_MAX;
					end else begin
						acc_d = word_sum[63:0];
					end
				end
				default: begin
					acc_we = 1'b0;
				end
			endcase
			// flag only, never a trap
			if (sat_evt) begin
				status_d[SAT_LSB + 32'(new_cmd.sum_pair_select)] = 1'b1;
			end
		end else if (wr && paddr == ADDR_STATUS) begin
			status_d = merge(status_q, pwdata, pstrb);
		end
	end

	// ----------------------------------------------------------------
	// registers written by software and the datapath
	// ----------------------------------------------------------------
	// control and operands
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RESET;
			ops_q  <= '0;
			cmd_q  <= '0;
		end else begin
			if (wr && paddr == ADDR_CTRL) begin
				ctrl_q <= merge(ctrl_q, pwdata, pstrb);
			end
			if (wr && paddr == ADDR_LEFT) begin
				ops_q.left_operand <= merge(ops_q.left_operand, pwdata, pstrb);
			end
			if (wr && paddr == ADDR_RIGHT) begin
				ops_q.right_operand <= merge(ops_q.right_operand, pwdata,
				                             pstrb);
			end
			if (issue) begin
				cmd_q <= new_cmd;
			end
		end
	end

	// extension status word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q <= STATUS_RESET;
		end else begin
			status_q <= status_d;
		end
	end

	// accumulator pairs; software may load either half directly
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 4; i++) begin
				acc_q[i] <= ACC_RESET;
			end
		end else if (acc_we) begin
			acc_q[new_cmd.sum_pair_select] <= acc_d;
		end else if (wr && is_acc(paddr)) begin
			if (acc_top) begin
				acc_q[acc_idx][63:32] <= merge(acc_q[acc_idx][63:32],
				                               pwdata, pstrb);
			end else begin
				acc_q[acc_idx][31:0] <= merge(acc_q[acc_idx][31:0],
				                              pwdata, pstrb);
			end
		end
	end

	// ----------------------------------------------------------------
	// interrupts: sticky, write-one-to-clear, set wins
	// ----------------------------------------------------------------
	logic [2:0] irq_set;
	logic [2:0] irq_clr;

	always_comb begin
		irq_set                = '0;
		irq_set[IRQ_DONE_BIT]  = issue && enabled;
		irq_set[IRQ_UNUSE_BIT] = issue && !enabled;
		irq_set[IRQ_SAT_BIT]   = sat_evt;
		irq_clr = (wr && paddr == ADDR_IRQ_STAT && pstrb[0]) ?
		          pwdata[2:0] : 3'h0;
		irq_stat_d = irq_set | (irq_stat_q & ~irq_clr);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= '0;
			irq_mask_q <= '0;
			unusable_q <= 1'b0;
		end else begin
			irq_stat_q <= irq_stat_d;
			unusable_q <= irq_set[IRQ_UNUSE_BIT];
			if (wr && paddr == ADDR_IRQ_MASK && pstrb[0]) begin
				irq_mask_q <= pwdata[2:0];
			end
		end
	end

	assign irq                = |(irq_stat_q & irq_mask_q);
	assign unusable_exception = unusable_q;

	// ----------------------------------------------------------------
	// read mux over flopped state
	// ----------------------------------------------------------------
	always_comb begin
		prdata = 32'h0000_0000;
		if (rd) begin
			if (is_acc(paddr)) begin
				prdata = acc_top ? acc_q[acc_idx][63:32] :
				                   acc_q[acc_idx][31:0];
			end else begin
				case (paddr)
					ADDR_CTRL:     prdata = ctrl_q;
					ADDR_LEFT:     prdata = ops_q.left_operand;
					ADDR_RIGHT:    prdata = ops_q.right_operand;
					ADDR_CMD:      prdata = {26'h0, cmd_q};
					ADDR_STATUS:   prdata = status_q;
					ADDR_IRQ_STAT: prdata = {29'h0, irq_stat_q};
					ADDR_IRQ_MASK: prdata = {29'h0, irq_mask_q};
					default:       prdata = 32'h0000_0000;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

/* File: simd_dot_pkg.sv */
// shared constants and types for the signal-processing compare and
// dot-product datapath: register offsets, field positions, op codes.
// assumes a 32-bit apb slave with byte addresses and aligned words.
package simd_dot_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL       = 8'h00;
	localparam logic [7:0] ADDR_LEFT       = 8'h04;
	localparam logic [7:0] ADDR_RIGHT      = 8'h08;
	localparam logic [7:0] ADDR_CMD        = 8'h0C;
	localparam logic [7:0] ADDR_STATUS     = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STAT   = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MASK   = 8'h18;
	localparam logic [7:0] ADDR_ACC_BASE   = 8'h20;
	localparam logic [7:0] ADDR_ACC_LAST   = 8'h3C;
	localparam int         ACC_STRIDE_LOG2 = 3;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int          CC_LSB        = 24;
	localparam int          SAT_LSB       = 16;
	localparam int          CTRL_EN_BIT   = 0;
	localparam int          IRQ_DONE_BIT  = 0;
	localparam int          IRQ_UNUSE_BIT = 1;
	localparam int          IRQ_SAT_BIT   = 2;
	localparam logic [31:0] STATUS_RESET  = 32'h0000_0000;
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
	localparam logic [63:0] ACC_RESET     = 64'h0000_0000_0000_0000;

	// ----------------------------------------------------------------
	// saturation constants
	// ----------------------------------------------------------------
	localparam logic [15:0] Q15_MIN = 16'h8000;
	localparam logic [31:0] Q31_MIN = 32'h8000_0000;
	localparam logic [31:0] Q31_MAX = 32'h7FFF_FFFF;
	localparam logic [63:0] Q63_MAX = 64'h7FFF_FFFF_FFFF_FFFF;
	localparam logic [63:0] Q63_MIN = 64'h8000_0000_0000_0000;

	// ----------------------------------------------------------------
	// operations and command word
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_NONE                         = 3'h0,
		OP_BYTE_LANES_EQUAL_COMPARE     = 3'h1,
		OP_BYTE_LANES_LESS_COMPARE      = 3'h2,
		OP_BYTE_LANES_LESS_EQUAL_COMPARE = 3'h3,
		OP_INTEGER_PAIR_DOT_ACCUMULATE  = 3'h4,
		OP_FRACTIONAL_PAIR_DOT_ACCUMULATE = 3'h5,
		OP_FRACTIONAL_WORD_SATURATING_MAC = 3'h6
	} op_t;

	typedef enum logic [1:0] {
		CMP_EQ = 2'h0,
		CMP_LT = 2'h1,
		CMP_LE = 2'h2
	} cmp_mode_t;

	typedef struct packed {
		logic [1:0] sum_pair_select;
		logic       pad;
		op_t        op;
	} cmd_t;

	typedef struct packed {
		logic [31:0] left_operand;
		logic [31:0] right_operand;
	} operands_t;

endpackage

/* File: byte_lane_compare.sv */
// four-lane unsigned byte comparator for the vector compare ops.
// assumes operands are stable while the result is sampled.
`timescale 1ns/1ps
`default_nettype none
module byte_lane_compare
	import simd_dot_pkg::*;
(
	// operands and mode
	input  wire simd_dot_pkg::operands_t ops,
	input  wire simd_dot_pkg::cmp_mode_t mode,
	// one flag per byte lane, lane 3 in bit 3
	output logic [3:0]                   flags
);

	// ----------------------------------------------------------------
	// per-lane compare
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			logic [7:0] a;
			logic [7:0] b;
			assign a = ops.left_operand[8*g +: 8];
			assign b = ops.right_operand[8*g +: 8];
			// unsigned compare per lane; msb lane lands in flag 3
			always_comb begin
				case (mode)
					CMP_EQ:  flags[g] = (a == b);
					CMP_LT:  flags[g] = (a <  b);
					CMP_LE:  flags[g] = (a <= b);
					default: flags[g] = 1'b0;
				endcase
			end
		end
	endgenerate

endmodule
`default_nettype wire

/* File: q15_multiply.sv */
// one q15 x q15 fractional multiply giving a q31 product with
// saturation of the single overflowing case.
// assumes signed halfword inputs; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module q15_multiply
	import simd_dot_pkg::*;
(
	// halfword multiplicands
	input  wire logic [15:0] a,
	input  wire logic [15:0] b,
	// q31 product and saturation mark
	output logic [31:0]      product,
	output logic             saturated
);

	// ----------------------------------------------------------------
	// product and the minus-one squared case
	// ----------------------------------------------------------------
	logic signed [31:0] raw;

	// only -1 x -1 overflows after the left shift
	always_comb begin
		raw       = 32'($signed(a)) * 32'($signed(b));
		saturated = (a == Q15_MIN) && (b == Q15_MIN);
		if (saturated) begin
			product = Q31_MAX;
		end else begin
			product = {raw[30:0], 1'b0};
		end
	end

endmodule
`default_nettype wire

/* File: simd_dot_assertions.sv */
// concurrent checks on the datapath's apb and event pins.
// assumes a bind onto simd_compare_dot_accumulate, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module simd_dot_assertions
	import simd_dot_pkg::*;
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// events
	input wire logic        irq,
	input wire logic        unusable_exception
);
	// ----------------------------------------------------------------
	// shadows of enable and unusable mask bit
	// ----------------------------------------------------------------
	logic en_q;
	logic msk_q;
	logic wr_ok;
	logic cmd_wr;
	logic trap_cause;
	assign wr_ok      = psel && penable && pwrite && pready && pstrb[0];
	assign cmd_wr     = wr_ok && (paddr == ADDR_CMD);
	assign trap_cause = cmd_wr && !en_q;
	// shadows follow software writes; the design never changes them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q  <= 1'b0;
			msk_q <= 1'b0;
		end else if (wr_ok && paddr == ADDR_CTRL) begin
			en_q <= pwdata[CTRL_EN_BIT];
		end else if (wr_ok && paddr == ADDR_IRQ_MASK) begin
			msk_q <= pwdata[IRQ_UNUSE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_cmd_enabled_quiet: assert property (
		cmd_wr && en_q |=> !unusable_exception)
		else $error("exception raised while enabled");
	chk_cmd_disabled_trap: assert property (
		trap_cause |=> unusable_exception)
		else $error("no exception for disabled command");
	chk_trap_one_cycle: assert property (
		unusable_exception |=> !unusable_exception)
		else $error("exception pulse too long");
	chk_trap_has_cause: assert property (
		unusable_exception |-> $past(trap_cause))
		else $error("exception without disabled command");
	chk_trap_irq_level: assert property (
		unusable_exception && msk_q |-> irq)
		else $error("masked-in exception gave no irq");
	chk_ready_no_wait: assert property (
		psel && penable |-> pready)
		else $error("access phase stalled");
	chk_pair_range_end: assert property (
		psel && penable && paddr > ADDR_ACC_LAST |->
		pslverr && prdata == 32'h0000_0000)
		else $error("address past last pair accepted");
	chk_pair_range_in: assert property (
		psel && penable && paddr >= ADDR_ACC_BASE &&
		paddr <= ADDR_ACC_LAST && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("pair address refused");
	cover property (cmd_wr && en_q);
	cover property (unusable_exception);
	cover property (irq);
endmodule
bind simd_compare_dot_accumulate simd_dot_assertions u_simd_dot_assertions (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
	.unusable_exception(unusable_exception));
`default_nettype wire

/* File: apb_host_model.sv */
// host side of the register bus: one apb transfer at a time.
// assumes the slave samples on the rising edge of pclk.
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
	// clock
	input wire logic         pclk,
	// request
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	output logic [3:0]       pstrb,
	// answer
	input wire logic [31:0]  prdata,
	input wire logic         pready,
	input wire logic         pslverr
);
	// ----------------------------------------------------------------
	// transfer
	// ----------------------------------------------------------------
	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0000_0000;
		pstrb   = 4'hF;
	end
	// answer is taken at the rising edge where pready is seen high,
	// before that edge's register updates land
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		logic rdy;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		rdy = 1'b0;
		while (rdy !== 1'b1) begin
			@(posedge pclk);
			rdy = pready;
			r = prdata;
			e = pslverr;
		end
		psel    <= 1'b0;
		penable <= 1'b0;
		pwdata  <= ~d; // released data never shows the old value
	endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the compare and dot-product datapath.
// assumes apb_host_model drives the bus and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import simd_dot_pkg::*;
	// ----------------------------------------------------------------
	// nets, design and host
	// ----------------------------------------------------------------
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, irq, unusable_exception;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	int fail_count = 0;
	int total_checks = 0;
	simd_compare_dot_accumulate u_simd_compare_dot_accumulate (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.unusable_exception(unusable_exception));
	apb_host_model u_apb_host_model (
		.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	always #20ns pclk = ~pclk;

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk32(string n, logic [31:0] x, logic [31:0] g);
		total_checks++;
		if (g !== x) begin
			$display("ERROR %s expected %h seen %h", n, x, g);
			fail_count++;
		end
	endtask
	task automatic chk64(string n, logic [63:0] x, logic [63:0] g);
		total_checks++;
		if (g !== x) begin
			$display("ERROR %s expected %h seen %h", n, x, g);
			fail_count++;
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		logic [31:0] r;
		logic e;
		u_apb_host_model.xfer(1'b1, a, d, r, e);
	endtask
	task automatic rd(logic [7:0] a, output logic [31:0] d);
		logic e;
		u_apb_host_model.xfer(1'b0, a, 32'h0000_0000, d, e);
	endtask
	// pair n: upper word first, lower word four bytes on
	task automatic wr_acc(logic [1:0] n, logic [63:0] v);
		wr(ADDR_ACC_BASE + {3'h0, n, 3'h0}, v[63:32]);
		wr(ADDR_ACC_BASE + {3'h0, n, 3'h4}, v[31:0]);
	endtask
	task automatic rd_acc(logic [1:0] n, output logic [63:0] v);
		rd(ADDR_ACC_BASE + {3'h0, n, 3'h0}, v[63:32]);
		rd(ADDR_ACC_BASE + {3'h0, n, 3'h4}, v[31:0]);
	endtask
	task automatic run_op(logic [1:0] s, logic [2:0] o, logic [31:0] l,
		logic [31:0] r);
		wr(ADDR_LEFT, l);
		wr(ADDR_RIGHT, r);
		wr(ADDR_CMD, {26'h0, s, 1'b0, o});
	endtask
	task automatic chk_sat(logic [3:0] x);
		logic [31:0] s;
		rd(ADDR_STATUS, s);
		chk32("saturation flags", {28'h0, x}, {28'h0, s[19:16]});
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_compare();
		logic [31:0] s;
		logic [3:0] x [3];
		x = '{4'hA, 4'h1, 4'hB}; // lanes 10/10 80/7F FF/FF 05/06
		for (int i = 0; i < 3; i++) begin
			run_op(2'h0, 3'(i + 1), 32'h1080_FF05, 32'h107F_FF06);
			rd(ADDR_STATUS, s);
			chk32("compare flags", {28'h0, x[i]}, {28'h0, s[27:24]});
		end
		$display("test compare done");
	endtask
	task automatic t_q15();
		logic [63:0] a;
		logic [31:0] s;
		wr(ADDR_IRQ_STAT, 32'h0000_0007);
		wr(ADDR_STATUS, 32'h0000_0000);
		run_op(2'h1, 3'h5, 32'h8000_4000, 32'h8000_C000);
		rd_acc(2'h1, a);
		chk64("q15 dot", 64'h0000_0000_5FFF_FFFF, a);
		wr(ADDR_CMD, {26'h0, 2'h1, 1'b0, 3'h5});
		rd_acc(2'h1, a);
		chk64("q15 dot twice", 64'h0000_0000_BFFF_FFFE, a);
		chk_sat(4'h2);
		rd(ADDR_IRQ_STAT, s);
		chk32("event flags", 32'h0000_0005, s);
		chk32("irq masked", 32'h0, {31'h0, irq});
		$display("test q15 dot done");
	endtask
	task automatic t_int_dot();
		logic [63:0] a;
		wr(ADDR_STATUS, 32'h0005_0000);
		wr_acc(2'h2, 64'h7FFF_FFFF_FFFF_FFFF);
		run_op(2'h2, 3'h4, 32'h8000_7FFF, 32'h8000_7FFF);
		rd_acc(2'h2, a);
		chk64("int dot wrap", 64'h8000_0000_7FFF_0000, a);
		run_op(2'h0, 3'h4, 32'h8000_0001, 32'h7FFF_FFFF);
		rd_acc(2'h0, a);
		chk64("int dot neg", 64'hFFFF_FFFF_C000_7FFF, a);
		rd_acc(2'h3, a);
		chk64("idle pair", ACC_RESET, a);
		chk_sat(4'h5);
		$display("test int dot done");
	endtask
	task automatic t_word_mac();
		logic [63:0] a;
		wr(ADDR_STATUS, 32'h0000_0000);
		run_op(2'h3, 3'h6, Q31_MIN, Q31_MIN);
		rd_acc(2'h3, a);
		chk64("word min squared", Q63_MAX, a);
		wr(ADDR_CMD, {26'h0, 2'h3, 1'b0, 3'h6});
		rd_acc(2'h3, a);
		chk64("word overflow", Q63_MAX, a);
		chk_sat(4'h8);
		wr_acc(2'h0, Q63_MIN);
		run_op(2'h0, 3'h6, Q31_MIN, 32'h4000_0000);
		rd_acc(2'h0, a);
		chk64("word underflow", Q63_MIN, a);
		wr_acc(2'h2, ACC_RESET);
		run_op(2'h2, 3'h6, 32'h4000_0000, 32'h4000_0000);
		rd_acc(2'h2, a);
		chk64("word plain", 64'h2000_0000_0000_0000, a);
		chk_sat(4'h9);
		$display("test word mac done");
	endtask
	task automatic t_disabled();
		logic [63:0] b, a;
		logic [31:0] s0, s1;
		logic e;
		wr(ADDR_IRQ_STAT, 32'h0000_0007);
		wr(ADDR_IRQ_MASK, 32'h0000_0002);
		wr(ADDR_CTRL, 32'h0000_0000);
		rd_acc(2'h1, b);
		rd(ADDR_STATUS, s0);
		run_op(2'h1, 3'h5, 32'h8000_8000, 32'h8000_8000);
		#1ns;
		chk32("unusable pulse", 32'h1, {31'h0, unusable_exception});
		rd_acc(2'h1, a);
		chk64("pair untouched", b, a);
		rd(ADDR_STATUS, s1);
		chk32("status untouched", s0, s1);
		chk32("irq raised", 32'h1, {31'h0, irq});
		wr(ADDR_IRQ_STAT, 32'h0000_0002);
		#1ns;
		chk32("irq cleared", 32'h0, {31'h0, irq});
		wr(ADDR_CTRL, 32'h0000_0001);
		u_apb_host_model.xfer(1'b0, 8'h40, 32'h0, s1, e);
		chk32("past last pair", 32'h1, {31'h0, e});
		$display("test disabled done");
	endtask

	// ----------------------------------------------------------------
	// sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		logic [63:0] a;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd_acc(2'h0, a);
		chk64("pair reset", ACC_RESET, a);
		wr(ADDR_CTRL, 32'h0000_0001);
		t_compare();
		t_q15();
		t_int_dot();
		t_word_mac();
		t_disabled();
		close_out();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		close_out();
	end
endmodule
`default_nettype wire
